/* address_gpio_pin_mux.sv */
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

module address_gpio_pin_mux
(
  input  wire logic                             clk_in,                 // System clock, 20 MHz
  input  wire logic                             nrst_in,                // Synchronous reset, active low
  // Avalon-MM slave
  input  wire logic [5:0]                       avs_address_in,         // Byte address
  input  wire logic                             avs_read_in,            // Read request
  input  wire logic                             avs_write_in,           // Write request
  input  wire logic [3:0]                       avs_byteenable_in,      // Byte lanes
  input  wire logic [31:0]                      avs_writedata_in,       // Write data
  output logic      [31:0]                      avs_readdata_out,       // Read data
  output logic                                  avs_waitrequest_out,    // Stall, high until answer
  // External memory interface side
  input  wire logic [1:0]                       ext_addr_bits_6_7_in,   // Address bits 7:6
  input  wire logic [7:0]                       ext_addr_bits_8_15_in,  // Address bits 15:8
  input  wire logic                             ext_bus_active_in,      // External access in progress
  output logic                                  ctrl_oe_out,            // Enable for memory control pins
  // Shared pads: bits 1:0 port E pins 2-3, bits 9:2 port A pins 0-7
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_in,                 // Pad levels, asynchronous
  output logic      [pin_mux_pkg::NUM_PINS-1:0] pad_out,                // Pad output value
  output logic      [pin_mux_pkg::NUM_PINS-1:0] pad_oe_out,             // Pad driver enable, high drives
  output logic      [pin_mux_pkg::NUM_PINS-1:0] pad_pullup_out          // Pull-up enable, high on
);

  import pin_mux_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  logic                   bus_drive_keep_reg;
  logic                   bus_drive_keep_next;
  logic [1:0]             e_pullup_reg;
  logic [1:0]             e_pullup_next;
  logic [7:0]             a_pullup_reg;
  logic [7:0]             a_pullup_next;
  logic [1:0]             e_periph_reg;
  logic [1:0]             e_periph_next;
  logic [7:0]             a_periph_reg;
  logic [7:0]             a_periph_next;
  logic [1:0]             e_dir_reg;
  logic [1:0]             e_dir_next;
  logic [7:0]             a_dir_reg;
  logic [7:0]             a_dir_next;
  logic [1:0]             e_data_reg;
  logic [1:0]             e_data_next;
  logic [7:0]             a_data_reg;
  logic [7:0]             a_data_next;
  logic [31:0]            readdata_reg;
  logic [31:0]            readdata_next;
  logic                   waitrequest_reg;
  logic                   waitrequest_next;
  logic                   write_take;
  logic [7:0]             wbyte;

  // Pad state
  logic [NUM_PINS-1:0]    pad_out_reg;
  logic [NUM_PINS-1:0]    pad_out_next;
  logic [NUM_PINS-1:0]    pad_oe_reg;
  logic [NUM_PINS-1:0]    pad_oe_next;
  logic [NUM_PINS-1:0]    pad_pullup_reg;
  logic [NUM_PINS-1:0]    pad_pullup_next;
  logic                   ctrl_oe_reg;
  logic                   ctrl_oe_next;
  logic [NUM_PINS-1:0]    pad_level;

  // Collected per-pin views: bit order matches the pad vector
  logic [NUM_PINS-1:0]    addr_vec;
  logic [NUM_PINS-1:0]    periph_vec;
  logic [NUM_PINS-1:0]    dir_vec;
  logic [NUM_PINS-1:0]    data_vec;
  logic [NUM_PINS-1:0]    pullup_vec;

  ////////////////////////////////////////////////////////////////////////////////
  // Pad input synchroniser
  pad_sync #(
    .WIDTH    (NUM_PINS)
  ) u_pad_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in (pad_in),
    .sync_out (pad_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the answer; write lands on the answering edge
  assign write_take = avs_write_in & ~waitrequest_reg;
  assign wbyte      = avs_writedata_in[7:0];

  always_comb
  begin
    waitrequest_next    = ~((avs_read_in | avs_write_in) & waitrequest_reg);
    readdata_next       = readdata_reg;
    bus_drive_keep_next = bus_drive_keep_reg;
    e_pullup_next       = e_pullup_reg;
    a_pullup_next       = a_pullup_reg;
    e_periph_next       = e_periph_reg;
    a_periph_next       = a_periph_reg;
    e_dir_next          = e_dir_reg;
    a_dir_next          = a_dir_reg;
    e_data_next         = e_data_reg;
    a_data_next         = a_data_reg;
    // Read data is captured in the wait cycle so it stands at the answering edge
    if (avs_read_in & waitrequest_reg)
    begin
      readdata_next = 32'h0000_0000; // Unmapped offsets read zero
      case (avs_address_in)
        OFS_BUS_CTRL: readdata_next[BUS_DRIVE_KEEP_BIT]     = bus_drive_keep_reg;
        OFS_E_PULLUP: readdata_next[PORT_E_MSB:PORT_E_LSB]  = e_pullup_reg;
        OFS_A_PULLUP: readdata_next[PORT_A_MSB:PORT_A_LSB]  = a_pullup_reg;
        OFS_E_PERIPH: readdata_next[PORT_E_MSB:PORT_E_LSB]  = e_periph_reg;
        OFS_A_PERIPH: readdata_next[PORT_A_MSB:PORT_A_LSB]  = a_periph_reg;
        OFS_E_DIR:    readdata_next[PORT_E_MSB:PORT_E_LSB]  = e_dir_reg;
        OFS_A_DIR:    readdata_next[PORT_A_MSB:PORT_A_LSB]  = a_dir_reg;
        OFS_E_DATA:   readdata_next[PORT_E_MSB:PORT_E_LSB]  = e_data_reg;
        OFS_A_DATA:   readdata_next[PORT_A_MSB:PORT_A_LSB]  = a_data_reg;
        OFS_E_LEVEL:  readdata_next[PORT_E_MSB:PORT_E_LSB]  = pad_level[1:0];
        OFS_A_LEVEL:  readdata_next[PORT_A_MSB:PORT_A_LSB]  = pad_level[9:2];
        default:      readdata_next                         = 32'h0000_0000;
      endcase
    end
    // All fields live in byte lane 0; other lanes and unmapped offsets are ignored
    if (write_take & avs_byteenable_in[0])
    begin
      case (avs_address_in)
        OFS_BUS_CTRL: bus_drive_keep_next = wbyte[BUS_DRIVE_KEEP_BIT];
        OFS_E_PULLUP: e_pullup_next = wbyte[PORT_E_MSB:PORT_E_LSB];
        OFS_A_PULLUP: a_pullup_next = wbyte[PORT_A_MSB:PORT_A_LSB];
        OFS_E_PERIPH: e_periph_next = wbyte[PORT_E_MSB:PORT_E_LSB];
        OFS_A_PERIPH: a_periph_next = wbyte[PORT_A_MSB:PORT_A_LSB];
        OFS_E_DIR:    e_dir_next    = wbyte[PORT_E_MSB:PORT_E_LSB];
        OFS_A_DIR:    a_dir_next    = wbyte[PORT_A_MSB:PORT_A_LSB];
        OFS_E_DATA:   e_data_next   = wbyte[PORT_E_MSB:PORT_E_LSB];
        OFS_A_DATA:   a_data_next   = wbyte[PORT_A_MSB:PORT_A_LSB];
        default:      ;
      endcase
    end
  end

  // Register stage for the bus and configuration
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      waitrequest_reg    <= 1'b1;
      readdata_reg       <= 32'h0000_0000;
      bus_drive_keep_reg <= BUS_DRIVE_KEEP_RST; // Default lets the bus float when idle
      e_pullup_reg       <= E_PULLUP_RST;
      a_pullup_reg       <= A_PULLUP_RST;
      e_periph_reg       <= E_PERIPH_RST;       // Address function after reset
      a_periph_reg       <= A_PERIPH_RST;
      e_dir_reg          <= E_DIR_RST;
      a_dir_reg          <= A_DIR_RST;
      e_data_reg         <= E_DATA_RST;
      a_data_reg         <= A_DATA_RST;
    end
    else
    begin
      waitrequest_reg    <= waitrequest_next;
      readdata_reg       <= readdata_next;
      bus_drive_keep_reg <= bus_drive_keep_next;
      e_pullup_reg       <= e_pullup_next;
      a_pullup_reg       <= a_pullup_next;
      e_periph_reg       <= e_periph_next;
      a_periph_reg       <= a_periph_next;
      e_dir_reg          <= e_dir_next;
      a_dir_reg          <= a_dir_next;
      e_data_reg         <= e_data_next;
      a_data_reg         <= a_data_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-pin views, port E in the low two bits, port A above
  assign addr_vec   = {ext_addr_bits_8_15_in, ext_addr_bits_6_7_in};
  assign periph_vec = {a_periph_reg, e_periph_reg};
  assign dir_vec    = {a_dir_reg, e_dir_reg};
  assign data_vec   = {a_data_reg, e_data_reg};
  assign pullup_vec = {a_pullup_reg, e_pullup_reg}; // Pull-up bit n serves pin n

  // Pad mux: address pins drive during an access, or always when drive-keep is set
  always_comb
  begin
    ctrl_oe_next = ext_bus_active_in | bus_drive_keep_reg;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (periph_vec[i])
      begin
        pad_out_next[i] = addr_vec[i];
        pad_oe_next[i]  = ctrl_oe_next;
      end
      else
      begin
        pad_out_next[i] = data_vec[i];
        pad_oe_next[i]  = dir_vec[i];
      end
      // Pull-up only when the pad is not driven, so it never fights the driver
      pad_pullup_next[i] = pullup_vec[i] & ~pad_oe_next[i];
    end
  end

  // Pad registers: reset releases drivers and turns pull-ups on
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      pad_out_reg    <= '0;
      pad_oe_reg     <= '0;
      pad_pullup_reg <= '1;
      ctrl_oe_reg    <= 1'b0;
    end
    else
    begin
      pad_out_reg    <= pad_out_next;
      pad_oe_reg     <= pad_oe_next;
      pad_pullup_reg <= pad_pullup_next;
      ctrl_oe_reg    <= ctrl_oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops
  assign avs_readdata_out    = readdata_reg;
  assign avs_waitrequest_out = waitrequest_reg;
  assign pad_out             = pad_out_reg;
  assign pad_oe_out          = pad_oe_reg;
  assign pad_pullup_out      = pad_pullup_reg;
  assign ctrl_oe_out         = ctrl_oe_reg;

endmodule // address_gpio_pin_mux

/* address_gpio_pin_mux_properties.sv */
`timescale 1ns/1ps
module pin_mux_checker
(
  input  wire logic                             clk_in,                // Clock
  input  wire logic                             nrst_in,               // Reset
  input  wire logic [5:0]                       avs_address_in,        // Address
  input  wire logic                             avs_write_in,          // Write
  input  wire logic [3:0]                       avs_byteenable_in,     // Lanes
  input  wire logic [31:0]                      avs_writedata_in,      // Data
  input  wire logic                             avs_waitrequest_out,   // Stall
  input  wire logic [1:0]                       ext_addr_bits_6_7_in,  // A7:6
  input  wire logic [7:0]                       ext_addr_bits_8_15_in, // A15:8
  input  wire logic                             ext_bus_active_in,     // Access
  input  wire logic                             ctrl_oe_out,           // Control enable
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_out,               // Pad value
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_oe_out,            // Pad enable
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_pullup_out         // Pull-ups
);
  import pin_mux_pkg::*;
  logic       keep_reg, keep_next;
  logic [9:0] per_reg, per_next, pur_reg, pur_next;
  logic [7:0] d;
  // Shadow of the drive-keep, peripheral-enable and pull-up registers; lanes other than 0 carry nothing
  always_comb
  begin
    d = avs_writedata_in[7:0];
    keep_next = keep_reg;
    per_next = per_reg;
    pur_next = pur_reg;
    if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0])
    begin
      case (avs_address_in)
        OFS_BUS_CTRL: keep_next = d[0];
        OFS_E_PULLUP: pur_next[1:0] = d[3:2];
        OFS_A_PULLUP: pur_next[9:2] = d;
        OFS_E_PERIPH: per_next[1:0] = d[3:2];
        OFS_A_PERIPH: per_next[9:2] = d;
        default: ;
      endcase
    end
  end
  // Registered shadow
  always_ff @(posedge clk_in)
  begin
    keep_reg <= nrst_in ? keep_next : BUS_DRIVE_KEEP_RST;
    per_reg <= nrst_in ? per_next : {A_PERIPH_RST, E_PERIPH_RST};
    pur_reg <= nrst_in ? pur_next : {A_PULLUP_RST, E_PULLUP_RST};
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_release;
    !nrst_in ##1 nrst_in;
  endsequence
  a_addr_low_route: assert property ($past(nrst_in) |->
    ((pad_out[1:0] ^ $past(ext_addr_bits_6_7_in)) & $past(per_reg[1:0])) == 2'h0) else $error("bad A7:6 pads");
  a_addr_high_route: assert property ($past(nrst_in) |->
    ((pad_out[9:2] ^ $past(ext_addr_bits_8_15_in)) & $past(per_reg[9:2])) == 8'h0) else $error("bad A15:8 pads");
  a_idle_addr_float: assert property ($past(nrst_in) |-> (pad_oe_out & $past(per_reg)) ==
    ($past(per_reg) & {10{$past(ext_bus_active_in) | $past(keep_reg)}})) else $error("bad address enable");
  a_idle_ctrl_float: assert property ($past(nrst_in) |->
    ctrl_oe_out == ($past(ext_bus_active_in) | $past(keep_reg))) else $error("bad control enable");
  a_release_addr_select: assert property (disable iff (1'b0) s_release |=>
    pad_out == $past({ext_addr_bits_8_15_in, ext_addr_bits_6_7_in})) else $error("no address after reset");
  a_pullup_port_e: assert property ($past(nrst_in) |->
    pad_pullup_out[1:0] == ($past(pur_reg[1:0]) & ~pad_oe_out[1:0])) else $error("bad port E pull-up");
  a_pullup_port_a: assert property ($past(nrst_in) |->
    pad_pullup_out[9:2] == ($past(pur_reg[9:2]) & ~pad_oe_out[9:2])) else $error("bad port A pull-up");
  a_reset_pads_quiet: assert property (disable iff (1'b0) !nrst_in [*2] |->
    pad_oe_out == 10'h000 && pad_pullup_out == 10'h3ff && !ctrl_oe_out) else $error("pads active in reset");
endmodule // pin_mux_checker

bind address_gpio_pin_mux pin_mux_checker i_pin_mux_checker (.clk_in, .nrst_in, .avs_address_in, .avs_write_in,
  .avs_byteenable_in, .avs_writedata_in, .avs_waitrequest_out, .ext_addr_bits_6_7_in, .ext_addr_bits_8_15_in,
  .ext_bus_active_in, .ctrl_oe_out, .pad_out, .pad_oe_out, .pad_pullup_out);

/* ext_mem_model.sv */
`timescale 1ns/1ps
module ext_mem_model
(
  input  wire logic                             clk_in,        // System clock
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_val_in,    // Device pad value
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_oe_in,     // Device drives
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_pullup_in, // Device pull-ups
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] drv_en_in,     // Far side drives
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0] drv_val_in,    // Far side value
  output logic      [pin_mux_pkg::NUM_PINS-1:0] level_out      // Resolved wire
);
  import pin_mux_pkg::*;
  logic [NUM_PINS-1:0] last_reg;
  // Wire level; an unpulled, undriven line flips so a stale value never reads back
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (pad_oe_in[i])
        level_out[i] = pad_val_in[i];
      else if (drv_en_in[i])
        level_out[i] = drv_val_in[i];
      else if (pad_pullup_in[i])
        level_out[i] = 1'b1;
      else
        level_out[i] = ~last_reg[i];
    end
  end
  // Last level seen
  always_ff @(posedge clk_in)
    last_reg <= level_out;
endmodule // ext_mem_model

/* pad_sync.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser for asynchronous pad levels
module pad_sync
#(
  parameter int unsigned WIDTH = 10
)
(
  input  wire logic             clk_in,  // System clock
  input  wire logic             nrst_in, // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] async_in, // Raw pad levels
  output logic      [WIDTH-1:0] sync_out  // Levels safe to read
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage2_next;

  // First stage feeds only the second, so no logic sees a metastable value
  always_comb
  begin
    stage1_next = async_in;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_out = stage2_reg;

endmodule // pad_sync

/* pin_mux_pkg.sv */
package pin_mux_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] OFS_BUS_CTRL   = 6'h00; // ext_bus_control_reg
  localparam logic [5:0] OFS_E_PULLUP   = 6'h04; // port_e_pullup_reg
  localparam logic [5:0] OFS_A_PULLUP   = 6'h08; // port_a_pullup_reg
  localparam logic [5:0] OFS_E_PERIPH   = 6'h0c; // port_e_periph_enable_reg
  localparam logic [5:0] OFS_A_PERIPH   = 6'h10; // port_a_periph_enable_reg
  localparam logic [5:0] OFS_E_DIR      = 6'h14; // port_e_dir_reg
  localparam logic [5:0] OFS_A_DIR      = 6'h18; // port_a_dir_reg
  localparam logic [5:0] OFS_E_DATA     = 6'h1c; // port_e_data_reg
  localparam logic [5:0] OFS_A_DATA     = 6'h20; // port_a_data_reg
  localparam logic [5:0] OFS_E_LEVEL    = 6'h24; // port_e_level_reg, read only
  localparam logic [5:0] OFS_A_LEVEL    = 6'h28; // port_a_level_reg, read only

  // Field layout
  localparam int unsigned BUS_DRIVE_KEEP_BIT = 0;  // bus_drive_keep in ext_bus_control_reg
  localparam int unsigned PORT_E_LSB         = 2;  // Port E pins 2 and 3 sit at bits 3:2
  localparam int unsigned PORT_E_MSB         = 3;
  localparam int unsigned PORT_A_LSB         = 0;  // Port A pin n sits at bit n
  localparam int unsigned PORT_A_MSB         = 7;
  localparam int unsigned NUM_PINS           = 10; // Pins 1:0 are port E, 9:2 are port A

  // Reset values
  localparam logic       BUS_DRIVE_KEEP_RST = 1'b0;
  localparam logic [1:0] E_PULLUP_RST       = 2'b11;
  localparam logic [7:0] A_PULLUP_RST       = 8'hff;
  localparam logic [1:0] E_PERIPH_RST       = 2'b11;
  localparam logic [7:0] A_PERIPH_RST       = 8'hff;
  localparam logic [1:0] E_DIR_RST          = 2'b00;
  localparam logic [7:0] A_DIR_RST          = 8'h00;
  localparam logic [1:0] E_DATA_RST         = 2'b00;
  localparam logic [7:0] A_DATA_RST         = 8'h00;

  // Synchroniser depth for pad inputs
  localparam int unsigned SYNC_STAGES = 2;

endpackage : pin_mux_pkg

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  import pin_mux_pkg::*;
  logic        clk_in, nrst_in, rd, wr, wreq, act, ctrl_oe;
  logic [5:0]  adr;
  logic [3:0]  be;
  logic [31:0] wd, rdata, q;
  logic [1:0]  a67;
  logic [7:0]  a815;
  logic [9:0]  pin, pv, poe, ppu, drv_en, drv_val;
  int          n_mismatch, comparisons;
  address_gpio_pin_mux i_address_gpio_pin_mux (.clk_in, .nrst_in, .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .ext_addr_bits_6_7_in(a67), .ext_addr_bits_8_15_in(a815),
    .ext_bus_active_in(act), .ctrl_oe_out(ctrl_oe), .pad_in(pin), .pad_out(pv), .pad_oe_out(poe),
    .pad_pullup_out(ppu));
  ext_mem_model i_ext_mem_model (.clk_in, .pad_val_in(pv), .pad_oe_in(poe), .pad_pullup_in(ppu),
    .drv_en_in(drv_en), .drv_val_in(drv_val), .level_out(pin));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One transfer; everything held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] l);
    int n;
    n = 0;
    @(posedge clk_in);
    adr <= a;
    wd <= d;
    be <= l;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (wreq !== 1'b0 && n < 40);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wreq !== 1'b0)
    begin
      n_mismatch++;
      test_done();
    end
  endtask
  // Pads settle one edge after a register or input change
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    bus(1'b0, OFS_A_PERIPH, 0, 4'hf);
    check(q, 32'hff);
    bus(1'b0, OFS_E_PULLUP, 0, 4'hf);
    check(q, 32'hc);
    bus(1'b0, 6'h3c, 0, 4'hf);
    check(q, 32'h0);
    $display("registers done");
  endtask
  task automatic t_address();
    a67 <= 2'b10;
    a815 <= 8'h5a;
    act <= 1'b1;
    tick(2);
    check(pin, {8'h5a, 2'b10});
    check(poe, 10'h3ff);
    act <= 1'b0;
    tick(2);
    check(poe, 10'h000);
    check(pin, 10'h3ff);
    bus(1'b1, OFS_BUS_CTRL, 32'h1, 4'hf);
    bus(1'b1, OFS_BUS_CTRL, 32'h0, 4'he);
    tick(2);
    check({ctrl_oe, poe}, 11'h7ff);
    bus(1'b0, OFS_BUS_CTRL, 0, 4'hf);
    check(q, 32'h1);
    bus(1'b1, OFS_BUS_CTRL, 32'h0, 4'hf);
    $display("address done");
  endtask
  task automatic t_pullup();
    bus(1'b1, OFS_E_PULLUP, 32'h8, 4'hf);
    bus(1'b1, OFS_A_PULLUP, 32'hfe, 4'hf);
    tick(2);
    check(ppu[1:0], 2'b10);
    check(ppu[9:2], 8'hfe);
    $display("pull-up done");
  endtask
  task automatic t_gpio();
    bus(1'b1, OFS_A_PERIPH, 32'h0, 4'hf);
    bus(1'b1, OFS_E_PERIPH, 32'h0, 4'hf);
    bus(1'b1, OFS_A_DIR, 32'h0f, 4'hf);
    bus(1'b1, OFS_A_DATA, 32'ha5, 4'hf);
    bus(1'b1, OFS_E_DIR, 32'h4, 4'hf);
    bus(1'b1, OFS_E_DATA, 32'h4, 4'hf);
    drv_en <= 10'h3c2;
    drv_val <= 10'h0c2;
    tick(4);
    check(poe, {8'h0f, 2'b01});
    check(pv, {8'ha5, 2'b01});
    check(ppu, {8'hf0, 2'b10});
    bus(1'b0, OFS_A_LEVEL, 0, 4'hf);
    check(q, 32'h35);
    bus(1'b0, OFS_E_LEVEL, 0, 4'hf);
    check(q, 32'hc);
    bus(1'b0, OFS_A_DIR, 0, 4'hf);
    check(q, 32'h0f);
    bus(1'b0, OFS_E_DIR, 0, 4'hf);
    check(q, 32'h4);
    bus(1'b0, OFS_E_PERIPH, 0, 4'hf);
    check(q, 32'h0);
    bus(1'b0, OFS_A_PULLUP, 0, 4'hf);
    check(q, 32'hfe);
    $display("port pins done");
  endtask
  ////////////////////////////////////////
  // Clock at 20 MHz
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Main sequence
  initial
  begin
    {nrst_in, rd, wr, act, adr, be, wd, a67, a815, drv_en, drv_val} = '0;
    // Nonzero address differs from the port data, so the mux choice after reset shows
    {a815, a67} = 10'h30d;
    tick(4);
    check({ctrl_oe, poe, ppu}, 21'h003ff);
    tick(12);
    nrst_in <= 1'b1;
    tick(2);
    check(pv, 10'h30d);
    check(poe, 10'h000);
    t_regs();
    t_address();
    t_pullup();
    t_gpio();
    test_done();
  end
endmodule // testbench
